//--- pcg_gate.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - bus master gate is writable bit 2 of command, reset zero
// - gate clear: inbound memory, I/O and MSI answered unsupported request
// - configuration and outbound traffic pass regardless of the gate
// - reset-cleared gate refuses inbound requests before host reset ends
// - memory claim enable is bit 1, steers target response to memory
// - memory enable set: claim both memory windows, low and high
// - memory enable clear: claim no memory, hub decodes subtractively
// - both enables reset zero; writable on every port other than 0, fixed zero on port 0
// - memory enable defaults zero so no window decodes until enabled
// - I/O enable set: claim I/O within base and limit window
// - I/O enable clear: claim no I/O, hub decodes subtractively
// - bridge error enable gates forwarding of received error messages
module pcg_gate
    import pcg_pkg::*;
#(
    parameter int PORT_NUM = 2
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire pcg_inb_t    inb_req,
    output logic             inb_accept,
    output logic             inb_ur,
    output logic             err_msg_fwd,
    input  wire pcg_dec_t    dec_req,
    output logic             dec_claim,
    output logic             dec_subtractive
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        bus_master_gate;
        logic        mem_window_claim_en;
        logic        io_window_claim_en;
        logic        bridge_err_msg_fwd_en;
        logic [31:0] mmio_base_limit;
        logic [31:0] prefetch_base_limit;
        logic [31:0] pf_upper_base;
        logic [31:0] pf_upper_limit;
        logic [31:0] io_window_reg;
        logic [15:0] ur_count;
        logic [31:0] prdata;
        logic        pslverr;
        logic        inb_accept;
        logic        inb_ur;
        logic        err_msg_fwd;
        logic        dec_claim;
        logic        dec_subtractive;
    } pcg_state_t;

    pcg_state_t st_reg;
    pcg_state_t st_next;

    localparam bit EN_WRITABLE = (PORT_NUM != 0);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic in_win(input logic [63:0] a,
                                    input logic [63:0] lo,
                                    input logic [63:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_win

    logic        wr_en;
    logic        rd_en;
    logic [15:0] cmd_word;
    logic [63:0] mem_lo;
    logic [63:0] mem_hi;
    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic [63:0] io_lo;
    logic [63:0] io_hi;
    logic        mem_hit;
    logic        io_hit;

    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    assign pready = 1'b1;

    assign cmd_word = {13'h0000, st_reg.bus_master_gate,
                       st_reg.mem_window_claim_en,
                       st_reg.io_window_claim_en};

    // windows: 1 MB granularity for memory, 4 KB for I/O
    assign mem_lo = {32'h0000_0000, st_reg.mmio_base_limit[15:4], 20'h0_0000};
    assign mem_hi = {32'h0000_0000, st_reg.mmio_base_limit[31:20],
                     20'hF_FFFF};
    assign pf_lo  = {st_reg.pf_upper_base,
                     st_reg.prefetch_base_limit[15:4], 20'h0_0000};
    assign pf_hi  = {st_reg.pf_upper_limit,
                     st_reg.prefetch_base_limit[31:20], 20'hF_FFFF};
    assign io_lo  = {48'h0000_0000_0000, st_reg.io_window_reg[7:4],
                     12'h000};
    assign io_hi  = {48'h0000_0000_0000, st_reg.io_window_reg[15:12],
                     12'hFFF};

    assign mem_hit = st_reg.mem_window_claim_en &&
                     (in_win(dec_req.addr, mem_lo, mem_hi) ||
                      in_win(dec_req.addr, pf_lo, pf_hi));
    assign io_hit  = st_reg.io_window_claim_en &&
                     in_win(dec_req.addr, io_lo, io_hi);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.inb_accept      = 1'b0;
        st_next.inb_ur          = 1'b0;
        st_next.err_msg_fwd     = 1'b0;
        st_next.dec_claim       = 1'b0;
        st_next.dec_subtractive = 1'b0;

        // enables take effect only after the write edge
        if (wr_en) begin
            case (paddr)
                PCG_CMD_OFS: begin
                    if (pstrb[0]) begin
                        st_next.bus_master_gate =
                            pwdata[PCG_GATE_BIT];
                        if (EN_WRITABLE) begin
                            st_next.mem_window_claim_en =
                                pwdata[PCG_MEMEN_BIT];
                            st_next.io_window_claim_en =
                                pwdata[PCG_IOEN_BIT];
                        end
                    end
                end
                PCG_BCTL_OFS: begin
                    if (pstrb[2]) begin
                        st_next.bridge_err_msg_fwd_en =
                            pwdata[16 + PCG_ERRFWD_BIT];
                    end
                end
                PCG_MEMW_OFS: st_next.mmio_base_limit =
                    merge(st_reg.mmio_base_limit, pwdata, pstrb);
                PCG_PFW_OFS:  st_next.prefetch_base_limit =
                    merge(st_reg.prefetch_base_limit, pwdata, pstrb);
                PCG_PFBU_OFS: st_next.pf_upper_base =
                    merge(st_reg.pf_upper_base, pwdata, pstrb);
                PCG_PFLU_OFS: st_next.pf_upper_limit =
                    merge(st_reg.pf_upper_limit, pwdata, pstrb);
                PCG_IOW_OFS:  st_next.io_window_reg =
                    merge(st_reg.io_window_reg, pwdata, pstrb);
                PCG_STAT_OFS: st_next.ur_count = 16'h0000;
                default: ;
            endcase
        end

        // read data registered in setup phase, valid in access phase
        if (psel && !penable) begin
            st_next.pslverr = 1'b0;
            st_next.prdata  = PCG_ZERO_WORD;
            case (paddr)
                PCG_CMD_OFS:  st_next.prdata = {16'h0000, cmd_word};
                PCG_BCTL_OFS: st_next.prdata = {14'h0000,
                    st_reg.bridge_err_msg_fwd_en, 17'h0_0000};
                PCG_MEMW_OFS: st_next.prdata = st_reg.mmio_base_limit;
                PCG_PFW_OFS:  st_next.prdata = st_reg.prefetch_base_limit;
                PCG_PFBU_OFS: st_next.prdata = st_reg.pf_upper_base;
                PCG_PFLU_OFS: st_next.prdata = st_reg.pf_upper_limit;
                PCG_IOW_OFS:  st_next.prdata = st_reg.io_window_reg;
                PCG_STAT_OFS: st_next.prdata = {16'h0000, st_reg.ur_count};
                default:      st_next.pslverr = 1'b1;
            endcase
            if (!rd_en) begin
                st_next.prdata = PCG_ZERO_WORD;
            end
        end else begin
            // drop data after the access phase so an idle bus reads zero
            st_next.pslverr = 1'b0;
            st_next.prdata  = PCG_ZERO_WORD;
        end

        // inbound gating
        if (inb_req.valid) begin
            case (inb_req.kind)
                PCG_REQ_MEM, PCG_REQ_IO, PCG_REQ_MSI: begin
                    if (st_reg.bus_master_gate) begin
                        st_next.inb_accept = 1'b1;
                    end else begin
                        st_next.inb_ur   = 1'b1;
                        st_next.ur_count = st_next.ur_count + 16'h0001;
                    end
                end
                PCG_REQ_ERRF, PCG_REQ_ERRN, PCG_REQ_ERRC: begin
                    st_next.inb_accept  = 1'b1;
                    st_next.err_msg_fwd =
                        st_reg.bridge_err_msg_fwd_en;
                end
                default: st_next.inb_accept = 1'b1;
            endcase
        end

        // downstream claim; unclaimed goes subtractive to hub
        if (dec_req.valid) begin
            st_next.dec_claim       = dec_req.is_io ? io_hit : mem_hit;
            st_next.dec_subtractive = !st_next.dec_claim;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata          = st_reg.prdata;
    assign pslverr         = st_reg.pslverr;
    assign inb_accept      = st_reg.inb_accept;
    assign inb_ur          = st_reg.inb_ur;
    assign err_msg_fwd     = st_reg.err_msg_fwd;
    assign dec_claim       = st_reg.dec_claim;
    assign dec_subtractive = st_reg.dec_subtractive;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_gate_ur_refuse: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        inb_req.valid && !st_reg.bus_master_gate &&
        (inb_req.kind inside {PCG_REQ_MEM, PCG_REQ_IO, PCG_REQ_MSI})
        |=> inb_ur && !inb_accept)
        else $error("gated inbound request not refused");
    a_gate_open_pass: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        inb_req.valid && st_reg.bus_master_gate
        |=> inb_accept && !inb_ur)
        else $error("inbound request refused while gate open");
    a_cfg_passes: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        inb_req.valid && inb_req.kind == PCG_REQ_CFG
        |=> inb_accept && !inb_ur)
        else $error("config request not passed");
    a_gate_write_lat: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        wr_en && paddr == PCG_CMD_OFS && pstrb[0]
        |=> st_reg.bus_master_gate == $past(pwdata[PCG_GATE_BIT]))
        else $error("gate bit write lost");
    a_port0_fixed: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !EN_WRITABLE |-> !st_reg.mem_window_claim_en &&
        !st_reg.io_window_claim_en)
        else $error("port 0 enables not zero");
    a_mem_claim: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        dec_req.valid && !dec_req.is_io && mem_hit
        |=> dec_claim && !dec_subtractive)
        else $error("memory window hit not claimed");
    a_mem_noclaim: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        dec_req.valid && !dec_req.is_io && !st_reg.mem_window_claim_en
        |=> !dec_claim && dec_subtractive)
        else $error("memory claimed while disabled");
    a_io_noclaim: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        dec_req.valid && dec_req.is_io && !st_reg.io_window_claim_en
        |=> !dec_claim && dec_subtractive)
        else $error("I/O claimed while disabled");
    a_io_claim: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        dec_req.valid && dec_req.is_io && io_hit |=> dec_claim)
        else $error("I/O window hit not claimed");
    a_claim_onehot: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        dec_req.valid |=> dec_claim != dec_subtractive)
        else $error("decode answer not exactly one of claim or hub");
    a_err_gate: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        err_msg_fwd |-> $past(st_reg.bridge_err_msg_fwd_en) &&
        $past(inb_req.valid))
        else $error("error message forwarded while gated");
    a_err_fwd_kind: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        err_msg_fwd |-> $past(inb_req.kind) inside
        {PCG_REQ_ERRF, PCG_REQ_ERRN, PCG_REQ_ERRC})
        else $error("non-error request flagged as forwarded message");

endmodule : pcg_gate

//--- pcg_pkg.sv
package pcg_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] PCG_CMD_OFS    = 12'h004;
    localparam logic [11:0] PCG_BCTL_OFS   = 12'h03C;
    localparam logic [11:0] PCG_MEMW_OFS   = 12'h020;
    localparam logic [11:0] PCG_PFW_OFS    = 12'h024;
    localparam logic [11:0] PCG_PFBU_OFS   = 12'h028;
    localparam logic [11:0] PCG_PFLU_OFS   = 12'h02C;
    localparam logic [11:0] PCG_IOW_OFS    = 12'h01C;
    localparam logic [11:0] PCG_STAT_OFS   = 12'h040;

    localparam int          PCG_IOEN_BIT   = 0;
    localparam int          PCG_MEMEN_BIT  = 1;
    localparam int          PCG_GATE_BIT   = 2;
    localparam int          PCG_ERRFWD_BIT = 1;
    localparam logic [15:0] PCG_CMD_RST    = 16'h0000;
    localparam logic [31:0] PCG_ZERO_WORD  = 32'h0000_0000;

    // ----------------------------------------------------------------
    // request kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PCG_REQ_MEM  = 3'b000,
        PCG_REQ_IO   = 3'b001,
        PCG_REQ_MSI  = 3'b010,
        PCG_REQ_CFG  = 3'b011,
        PCG_REQ_ERRF = 3'b100,
        PCG_REQ_ERRN = 3'b101,
        PCG_REQ_ERRC = 3'b110,
        PCG_REQ_OTH  = 3'b111
    } pcg_kind_t;

    typedef struct packed {
        logic        valid;
        pcg_kind_t   kind;
    } pcg_inb_t;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [63:0] addr;
    } pcg_dec_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
    } pcg_apb_rsp_t;

endpackage : pcg_pkg

//--- pcg_link_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: link partner issuing inbound requests
// ----------------------------------------------------------------
module pcg_link_model
    import pcg_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic host_core_reset_n,
    output pcg_inb_t  inb_req
);
    initial inb_req = '0;

    // early set only to model a misbehaving device before host reset ends
    task automatic send(input pcg_kind_t k, input logic early);
        while (!early && !host_core_reset_n) @(posedge clk_sys);
        @(posedge clk_sys);
        inb_req <= '{valid: 1'b1, kind: k};
        @(posedge clk_sys);
        // stale kind flipped so nothing leans on a released value
        inb_req <= '{valid: 1'b0, kind: pcg_kind_t'(~k)};
    endtask : send
endmodule : pcg_link_model

//--- pcg_gate_tb.sv
`timescale 1ns/1ps
module pcg_gate_tb
    import pcg_pkg::*;
;
    logic        clk_sys = 0;
    logic        rst_b = 0;
    logic        host_core_reset_n = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata, rd0, rd, rd0_s;
    logic        pready, pslverr, err_s, inb_accept, inb_ur, err_msg_fwd;
    logic        dec_claim, dec_subtractive, claim0;
    pcg_inb_t    inb_req;
    pcg_dec_t    dec_req = '0;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    pcg_gate #(.PORT_NUM(2)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .inb_req(inb_req),
        .inb_accept(inb_accept), .inb_ur(inb_ur),
        .err_msg_fwd(err_msg_fwd), .dec_req(dec_req),
        .dec_claim(dec_claim), .dec_subtractive(dec_subtractive));
    pcg_gate #(.PORT_NUM(0)) dut0 (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(rd0),
        .pready(), .pslverr(), .inb_req(inb_req),
        .inb_accept(), .inb_ur(), .err_msg_fwd(),
        .dec_req(dec_req), .dec_claim(claim0), .dec_subtractive());
    pcg_link_model link (.clk_sys(clk_sys),
        .host_core_reset_n(host_core_reset_n), .inb_req(inb_req));

    always #25 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // no fixed latency assumed: access waits for pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        rd0_s = rd0;
        err_s = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic inb(input pcg_kind_t k, input logic ur, fwd, early);
        link.send(k, early);
        @(negedge clk_sys);
        chk("inb_accept", !ur, inb_accept);
        chk("inb_ur", ur, inb_ur);
        chk("err_msg_fwd", fwd, err_msg_fwd);
    endtask : inb

    task automatic dec(input logic io, input logic [63:0] a, input logic e);
        @(posedge clk_sys);
        dec_req <= '{valid: 1'b1, is_io: io, addr: a};
        @(posedge clk_sys);
        dec_req.valid <= 1'b0;
        @(negedge clk_sys);
        chk("dec_claim", e, dec_claim);
        chk("dec_subtractive", !e, dec_subtractive);
        chk("claim_port0", 0, claim0);
    endtask : dec

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        apb(0, PCG_CMD_OFS, 0);
        chk("cmd_reset", 32'h0000_0000, rd);
        inb(PCG_REQ_MEM, 1, 0, 1);
        @(posedge clk_sys);
        host_core_reset_n <= 1'b1;
        apb(1, PCG_MEMW_OFS, 32'h0020_0010);
        apb(1, PCG_PFW_OFS, 32'h0050_0040);
        apb(1, PCG_PFBU_OFS, 32'h0000_0001);
        apb(1, PCG_PFLU_OFS, 32'h0000_0001);
        apb(1, PCG_IOW_OFS, 32'h0000_2010);
        dec(0, 64'h0010_0000, 0);
        dec(1, 64'h0000_1000, 0);
        for (int k = 0; k < 8; k++) begin
            inb(pcg_kind_t'(k), k < 3, 0, 0);
        end
        apb(1, PCG_CMD_OFS, 32'hFFFF_FFFF);
        apb(0, PCG_CMD_OFS, 0);
        chk("cmd_rw", 32'h0000_0007, rd);
        chk("cmd_port0", 32'h0000_0004, rd0_s);
        for (int k = 0; k < 8; k++) begin
            inb(pcg_kind_t'(k), 0, 0, 0);
        end
        apb(1, PCG_BCTL_OFS, 32'h0002_0000);
        apb(0, PCG_BCTL_OFS, 0);
        chk("bctl_fwd", 32'h0002_0000, rd);
        for (int k = 4; k < 7; k++) begin
            inb(pcg_kind_t'(k), 0, 1, 0);
        end
        inb(PCG_REQ_MEM, 0, 0, 0);
        dec(0, 64'h0010_0000, 1);
        dec(0, 64'h002F_FFF0, 1);
        dec(0, 64'h0030_0000, 0);
        dec(0, 64'h0001_0040_0000, 1);
        dec(1, 64'h0000_1000, 1);
        dec(1, 64'h0000_2FFF, 1);
        dec(1, 64'h0000_3000, 0);
        apb(1, PCG_CMD_OFS, 32'h0000_0005);
        dec(0, 64'h0010_0000, 0);
        dec(1, 64'h0000_1000, 1);
        apb(1, PCG_CMD_OFS, 32'h0000_0004);
        dec(1, 64'h0000_1000, 0);
        apb(1, PCG_CMD_OFS, 32'h0000_0000);
        inb(PCG_REQ_MSI, 1, 0, 0);
        // five refusals so far: one early, three gated, one msi
        apb(0, PCG_STAT_OFS, 0);
        chk("ur_count", 32'h0000_0005, rd);
        apb(1, PCG_STAT_OFS, 0);
        apb(0, PCG_STAT_OFS, 0);
        chk("ur_clear", 32'h0000_0000, rd);
        // unmapped place: error response, reads zero, write dropped
        apb(1, 12'h100, 32'hFFFF_FFFF);
        chk("unmapped_err", 1, err_s);
        apb(0, 12'h100, 0);
        chk("unmapped_rd", 32'h0000_0000, rd);
        chk("unmapped_err", 1, err_s);
        apb(0, PCG_CMD_OFS, 0);
        chk("cmd_kept", 32'h0000_0000, rd);
        chk("cmd_err", 0, err_s);
        end_sim();
    end
endmodule : pcg_gate_tb
